// [logic/cwp_code_protect.v]
// Behaviour
// - Config bits read 0 once programmed, 1 while unprogrammed.
// - Bit 9 one enables program-memory parity checking, zero disables.
// - Bits 7-6: 00 all, 01 upper 3/4, 10 upper half, 11 none protected.
// - Bit 8 one enables brown-out detection, zero disables it.
// - Bit 5 active low: zero enables power-up timer.
// - Bit 4 one enables watchdog, zero disables it.
// - Bits 3-2 pick resistor-capacitor, high-speed, standard or low-power crystal clock.
// - Bits 1-0 parity move with the word but are never checked.
// - Protected segments read zero and refuse programming.
// - Unprotected memory, ID words, config word always readable and programmable.
// - Protection once programmed can never be undone.
// - Configuration-load sets the program counter to 0x2000.
`timescale 1ns/1ps
`default_nettype none
`include "cwp_defines.vh"

module cwp_code_protect (
    input wire clock_i,
    input wire rst_n_i,
    input wire blank_i,
    input wire load_config_i,
    input wire load_data_i,
    input wire [15:0] load_word_i,
    input wire read_i,
    input wire incr_i,
    input wire begin_prog_i,
    input wire end_prog_i,
    output reg [15:0] read_word_o,
    output reg read_valid_o,
    output reg [13:0] pc_o,
    output reg prog_active_o,
    output reg prog_refused_o,
    output reg parity_check_enable_o,
    output reg brownout_enable_o,
    output reg protect_select_high_o,
    output reg protect_select_low_o,
    output reg powerup_timer_enable_n_o,
    output reg watchdog_enable_o,
    output reg osc_select_high_o,
    output reg osc_select_low_o
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOADED = 3'b010;
    localparam [2:0] ST_PROG = 3'b100;

    // Non-volatile cells: no reset, only blank_i (fresh die) sets them to ones
    reg [15:0] user_mem [0:`CWP_MEM_DEPTH-1];
    reg [15:0] id_word_0;
    reg [15:0] id_word_1;
    reg [15:0] id_word_2;
    reg [15:0] id_word_3;
    reg [15:0] device_config_word;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [13:0] pc_nxt;
    reg [15:0] latch_r;
    reg [13:0] prog_addr_r;
    integer i;

    wire dec_parity;
    wire dec_brownout;
    wire [1:0] dec_protect;
    wire dec_pwrt_n;
    wire dec_wdt;
    wire [1:0] dec_osc;

    cwp_cfg_decode u_decode (
        .cfg_word_i(device_config_word),
        .parity_check_enable_o(dec_parity),
        .brownout_enable_o(dec_brownout),
        .protect_select_o(dec_protect),
        .powerup_timer_enable_n_o(dec_pwrt_n),
        .watchdog_enable_o(dec_wdt),
        .osc_select_o(dec_osc),
        .word_parity_o()
    );

    // Only user memory can be protected; config space never is
    function is_protected;
        input [13:0] addr;
        input [1:0] sel;
        begin
            if (addr[`CWP_CFG_SPACE_BIT]) begin
                is_protected = 1'b0;
            end else begin
                case (sel)
                    `CWP_PROTECT_ALL: is_protected = 1'b1;
                    `CWP_PROTECT_UPPER_3Q:
                        is_protected = addr[10:0] >= `CWP_QUARTER_LIMIT;
                    `CWP_PROTECT_UPPER_HALF:
                        is_protected = addr[10:0] >= `CWP_HALF_LIMIT;
                    default: is_protected = 1'b0;
                endcase
            end
        end
    endfunction

    // True contents of a location, before protection is applied
    function [15:0] raw_word;
        input [13:0] addr;
        begin
            if (!addr[`CWP_CFG_SPACE_BIT]) begin
                raw_word = user_mem[addr[10:0]];
            end else begin
                case (addr)
                    `CWP_ID_WORD_0_ADDR: raw_word = id_word_0;
                    `CWP_ID_WORD_0_ADDR + 14'h0001: raw_word = id_word_1;
                    `CWP_ID_WORD_0_ADDR + 14'h0002: raw_word = id_word_2;
                    `CWP_ID_WORD_3_ADDR: raw_word = id_word_3;
                    `CWP_DEVICE_CONFIG_WORD_ADDR: raw_word = device_config_word;
                    default: raw_word = `CWP_READ_RESERVED;
                endcase
            end
        end
    endfunction

    // Program counter stepping: user space wraps in 0x0000-0x1FFF,
    // config space stays in 0x2000-0x20FF
    always @* begin
        pc_nxt = pc_o;
        if (load_config_i) begin
            pc_nxt = `CWP_CFG_SPACE_BASE;
        end else if (incr_i) begin
            if (pc_o[`CWP_CFG_SPACE_BIT]) begin
                pc_nxt = `CWP_CFG_SPACE_BASE | ((pc_o + 14'h0001) & `CWP_CFG_WRAP_MASK);
            end else begin
                pc_nxt = (pc_o + 14'h0001) & `CWP_USER_WRAP_MASK;
            end
        end
    end

    // A programming pulse needs a preceding load; end without begin is ignored
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (load_config_i || load_data_i) begin
                    state_nxt = ST_LOADED;
                end
            end
            ST_LOADED: begin
                if (begin_prog_i) begin
                    state_nxt = ST_PROG;
                end
            end
            ST_PROG: begin
                if (end_prog_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            pc_o <= `CWP_PC_RESET;
            latch_r <= `CWP_BLANK_WORD;
            prog_addr_r <= `CWP_PC_RESET;
            read_word_o <= 16'h0000;
            read_valid_o <= 1'b0;
            prog_active_o <= 1'b0;
            prog_refused_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_o <= pc_nxt;
            if ((load_config_i || load_data_i) && state_r != ST_PROG) begin
                latch_r <= load_word_i;
            end
            if (state_r == ST_LOADED && begin_prog_i) begin
                prog_addr_r <= pc_o;
            end
            read_valid_o <= read_i;
            if (read_i) begin
                // Protected words read zero; everything else reads true
                read_word_o <= is_protected(pc_o, dec_protect) ?
                               `CWP_READ_PROTECTED : raw_word(pc_o);
            end
            prog_active_o <= state_nxt == ST_PROG;
            prog_refused_o <= state_r == ST_PROG && end_prog_i &&
                              is_protected(prog_addr_r, dec_protect);
        end
    end

    // Cells only ever go from 1 to 0, so cleared protect bits stay cleared
    always @(posedge clock_i) begin
        if (blank_i) begin
            for (i = 0; i < `CWP_MEM_DEPTH; i = i + 1) begin
                user_mem[i] <= `CWP_BLANK_WORD;
            end
            id_word_0 <= `CWP_BLANK_WORD;
            id_word_1 <= `CWP_BLANK_WORD;
            id_word_2 <= `CWP_BLANK_WORD;
            id_word_3 <= `CWP_BLANK_WORD;
            device_config_word <= `CWP_BLANK_WORD;
        end else if (rst_n_i && state_r == ST_PROG && end_prog_i &&
                     !is_protected(prog_addr_r, dec_protect)) begin
            if (!prog_addr_r[`CWP_CFG_SPACE_BIT]) begin
                user_mem[prog_addr_r[10:0]] <= user_mem[prog_addr_r[10:0]] & latch_r;
            end else begin
                case (prog_addr_r)
                    `CWP_ID_WORD_0_ADDR: id_word_0 <= id_word_0 & latch_r;
                    `CWP_ID_WORD_0_ADDR + 14'h0001: id_word_1 <= id_word_1 & latch_r;
                    `CWP_ID_WORD_0_ADDR + 14'h0002: id_word_2 <= id_word_2 & latch_r;
                    `CWP_ID_WORD_3_ADDR: id_word_3 <= id_word_3 & latch_r;
                    `CWP_DEVICE_CONFIG_WORD_ADDR:
                        device_config_word <= device_config_word & latch_r;
                    default: id_word_0 <= id_word_0;
                endcase
            end
        end
    end

    // Decoded settings registered so every output leaves a flip-flop
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            parity_check_enable_o <= 1'b1;
            brownout_enable_o <= 1'b1;
            protect_select_high_o <= 1'b1;
            protect_select_low_o <= 1'b1;
            powerup_timer_enable_n_o <= 1'b1;
            watchdog_enable_o <= 1'b1;
            osc_select_high_o <= 1'b1;
            osc_select_low_o <= 1'b1;
        end else begin
            parity_check_enable_o <= dec_parity;
            brownout_enable_o <= dec_brownout;
            protect_select_high_o <= dec_protect[1];
            protect_select_low_o <= dec_protect[0];
            powerup_timer_enable_n_o <= dec_pwrt_n;
            watchdog_enable_o <= dec_wdt;
            osc_select_high_o <= dec_osc[1];
            osc_select_low_o <= dec_osc[0];
        end
    end
endmodule // cwp_code_protect

`default_nettype wire

// [logic/cwp_defines.vh]
`ifndef CWP_DEFINES_VH
`define CWP_DEFINES_VH

// Address map in programming mode (14-bit program counter)
`define CWP_PC_W 14
`define CWP_PC_RESET 14'h0000
`define CWP_CFG_SPACE_BASE 14'h2000
`define CWP_ID_WORD_0_ADDR 14'h2000
`define CWP_ID_WORD_3_ADDR 14'h2003
`define CWP_DEVICE_CONFIG_WORD_ADDR 14'h2007
`define CWP_CFG_SPACE_BIT 13
`define CWP_USER_WRAP_MASK 14'h1FFF
`define CWP_CFG_WRAP_MASK 14'h00FF

// Implemented user memory: 0x000..0x7FF
`define CWP_MEM_AW 11
`define CWP_MEM_DEPTH 2048
`define CWP_QUARTER_LIMIT 11'h200
`define CWP_HALF_LIMIT 11'h400

// Cell state
`define CWP_WORD_W 16
`define CWP_BLANK_WORD 16'hFFFF
`define CWP_READ_PROTECTED 16'h0000
`define CWP_READ_RESERVED 16'h0000

// Configuration word fields
`define CWP_PARITY_CHECK_BIT 9
`define CWP_BROWNOUT_BIT 8
`define CWP_PROTECT_HIGH_BIT 7
`define CWP_PROTECT_LOW_BIT 6
`define CWP_POWERUP_TIMER_N_BIT 5
`define CWP_WATCHDOG_BIT 4
`define CWP_OSC_HIGH_BIT 3
`define CWP_OSC_LOW_BIT 2
`define CWP_WORD_PARITY_HIGH_BIT 1
`define CWP_WORD_PARITY_LOW_BIT 0

// Protection range codes
`define CWP_PROTECT_ALL 2'h0
`define CWP_PROTECT_UPPER_3Q 2'h1
`define CWP_PROTECT_UPPER_HALF 2'h2
`define CWP_PROTECT_OFF 2'h3

// Oscillator codes
`define CWP_RESISTOR_CAPACITOR_OSC 2'h3
`define CWP_HIGH_SPEED_CRYSTAL 2'h2
`define CWP_STANDARD_CRYSTAL 2'h1
`define CWP_LOW_POWER_CRYSTAL 2'h0

`endif

// [logic/cwp_cfg_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "cwp_defines.vh"

module cwp_cfg_decode (
    input wire [15:0] cfg_word_i,
    output wire parity_check_enable_o,
    output wire brownout_enable_o,
    output wire [1:0] protect_select_o,
    output wire powerup_timer_enable_n_o,
    output wire watchdog_enable_o,
    output wire [1:0] osc_select_o,
    output wire [1:0] word_parity_o
);
    // Programmed bit reads 0, unprogrammed reads 1; fields pass as stored
    assign parity_check_enable_o = cfg_word_i[`CWP_PARITY_CHECK_BIT];
    assign brownout_enable_o = cfg_word_i[`CWP_BROWNOUT_BIT];
    assign protect_select_o = {cfg_word_i[`CWP_PROTECT_HIGH_BIT],
                               cfg_word_i[`CWP_PROTECT_LOW_BIT]};
    assign powerup_timer_enable_n_o = cfg_word_i[`CWP_POWERUP_TIMER_N_BIT];
    assign watchdog_enable_o = cfg_word_i[`CWP_WATCHDOG_BIT];
    assign osc_select_o = {cfg_word_i[`CWP_OSC_HIGH_BIT],
                           cfg_word_i[`CWP_OSC_LOW_BIT]};
    // Carried for visibility only, never checked
    assign word_parity_o = {cfg_word_i[`CWP_WORD_PARITY_HIGH_BIT],
                            cfg_word_i[`CWP_WORD_PARITY_LOW_BIT]};
endmodule // cwp_cfg_decode

`default_nettype wire

// [verification/cwp_prog.sv]
`timescale 1ns/1ps
`default_nettype none
module cwp_prog (
    input wire logic clock_i,
    input wire logic [15:0] read_word_i,
    input wire logic prog_refused_i,
    output logic [5:0] cmd_o,
    output logic [15:0] word_o
);
    logic supply_ceiling_level; // Rig rail: high at the ceiling, low at the floor
    initial begin
        cmd_o = 6'h00;
        word_o = 16'h0000;
        supply_ceiling_level = 1'b0;
    end
    // Bits: load config, load data, read, incr, begin, end
    task cmd(input logic [5:0] c, input logic [15:0] w);
        @(posedge clock_i);
        #1;
        cmd_o = c;
        word_o = w;
        @(posedge clock_i);
        #1;
        cmd_o = 6'h00;
        word_o = ~w; // Released line must not keep the old value
    endtask
    task rd(output logic [15:0] d);
        cmd(6'h08, 16'h0000);
        d = read_word_i;
    endtask
    task step(input int n);
        repeat (n) cmd(6'h04, 16'h0000);
    endtask
    // Same word read back with the rig at both supply limits
    task verify(output logic [15:0] at_floor, output logic [15:0] at_ceiling);
        supply_ceiling_level = 1'b0;
        rd(at_floor);
        supply_ceiling_level = 1'b1;
        rd(at_ceiling);
    endtask
    task prog(input logic [15:0] w, output logic refused);
        cmd(6'h10, w);
        cmd(6'h02, 16'h0000);
        cmd(6'h01, 16'h0000);
        refused = prog_refused_i;
    endtask
    // Plain read-out sum; protected words already read zero
    task checksum(input logic with_id, output logic [15:0] sum);
        logic [15:0] d;
        logic [15:0] pk;
        sum = 16'h0000;
        pk = 16'h0000;
        repeat (2048) begin
            rd(d);
            sum = sum + d;
            step(1);
        end
        cmd(6'h20, 16'hFFFF);
        repeat (4) begin
            rd(d);
            pk = {pk[11:0], d[3:0]};
            step(1);
        end
        step(3);
        rd(d);
        sum = sum + (d & 16'h3FFF) + (with_id ? pk : 16'h0000);
    endtask
endmodule // cwp_prog
`default_nettype wire

// [verification/cwp_code_protect_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module cwp_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic blank_i,
    input wire logic load_config_i,
    input wire logic read_i,
    input wire logic incr_i,
    input wire logic begin_prog_i,
    input wire logic end_prog_i,
    input wire logic [15:0] read_word_o,
    input wire logic read_valid_o,
    input wire logic [13:0] pc_o,
    input wire logic prog_active_o,
    input wire logic prog_refused_o,
    input wire logic parity_check_enable_o,
    input wire logic brownout_enable_o,
    input wire logic protect_select_high_o,
    input wire logic protect_select_low_o,
    input wire logic powerup_timer_enable_n_o,
    input wire logic watchdog_enable_o,
    input wire logic osc_select_high_o,
    input wire logic osc_select_low_o
);
    wire [1:0] sel = {protect_select_high_o, protect_select_low_o};
    wire [7:0] dec = {parity_check_enable_o, brownout_enable_o, sel, powerup_timer_enable_n_o,
        watchdog_enable_o, osc_select_high_o, osc_select_low_o};
    logic [13:0] wa_r;
    function automatic logic prot_f(input logic [13:0] a, input logic [1:0] s);
        prot_f = !a[13] && (s == 2'h0 || (s == 2'h1 && a[10:0] >= 11'h200)
            || (s == 2'h2 && a[10:0] >= 11'h400));
    endfunction
    // Target of the pulse is fixed at begin, not at end
    always @(posedge clock_i) begin
        if (begin_prog_i && !prog_active_o) wa_r <= pc_o;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    prot_read_a: assert property (
        read_i && prot_f(pc_o, sel) |=> read_word_o == 16'h0000)
        else $error("protected read not zero");
    prot_write_a: assert property (
        end_prog_i && prog_active_o && prot_f(wa_r, sel) |=> prog_refused_o)
        else $error("protected write not refused");
    open_write_a: assert property (
        end_prog_i && prog_active_o && !prot_f(wa_r, sel) |=> !prog_refused_o)
        else $error("open write refused");
    refuse_pulse_a: assert property ($rose(prog_refused_o) |=> !prog_refused_o)
        else $error("refusal longer than one cycle");
    read_answer_a: assert property (read_i |=> read_valid_o)
        else $error("read not answered");
    pulse_end_a: assert property (end_prog_i && prog_active_o |=> !prog_active_o)
        else $error("programming pulse did not end");
    cfg_pc_a: assert property (load_config_i |=> pc_o == 14'h2000)
        else $error("config load pc wrong");
    cfg_step_a: assert property (
        incr_i && !load_config_i && pc_o[13] && pc_o[7:0] != 8'hFF
        |=> pc_o == $past(pc_o) + 14'h0001) else $error("config increment wrong");
    prot_keep_a: assert property (
        (rst_n_i && !blank_i)[*3] |=> ((~$past(sel)) & sel) == 2'h0)
        else $error("protection undone");
    decode_eq_a: assert property (
        read_valid_o && $past(pc_o) == 14'h2007 && !$past(blank_i)
        |-> dec == read_word_o[9:2]) else $error("decoded bits differ from word");
    c_refuse: cover property (prog_refused_o);
    c_prot_rd: cover property (read_i && prot_f(pc_o, sel));
    c_full: cover property (sel == 2'h0);
endmodule // cwp_chk
bind cwp_code_protect cwp_chk u_cwp_chk (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .blank_i(blank_i),
    .load_config_i(load_config_i),
    .read_i(read_i),
    .incr_i(incr_i),
    .begin_prog_i(begin_prog_i),
    .end_prog_i(end_prog_i),
    .read_word_o(read_word_o),
    .read_valid_o(read_valid_o),
    .pc_o(pc_o),
    .prog_active_o(prog_active_o),
    .prog_refused_o(prog_refused_o),
    .parity_check_enable_o(parity_check_enable_o),
    .brownout_enable_o(brownout_enable_o),
    .protect_select_high_o(protect_select_high_o),
    .protect_select_low_o(protect_select_low_o),
    .powerup_timer_enable_n_o(powerup_timer_enable_n_o),
    .watchdog_enable_o(watchdog_enable_o),
    .osc_select_high_o(osc_select_high_o),
    .osc_select_low_o(osc_select_low_o)
);
`default_nettype wire

// [verification/cwp_code_protect_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cwp_code_protect_test;
    logic clock_i, rst_n_i, blank_i, rv, pa, refused, r;
    logic [5:0] cmd;
    logic [15:0] word, rd_w, cfg, d, d2, sum;
    logic [13:0] pc;
    logic [7:0] dec;
    int n_mismatch, n_tests, cyc, m, i, pos;
    // Rows: address, data, protected under codes 3..0
    logic [10:0] ra [5] = '{11'h1FF, 11'h200, 11'h3FF, 11'h400, 11'h7FF};
    logic [15:0] rdt [5] = '{16'h25E6, 16'h1234, 16'hA5A5, 16'h0F0F, 16'h7E81};
    logic [3:0] rp [5] = '{4'h1, 4'h3, 4'h3, 4'h7, 4'h7};
    cwp_code_protect u_cwp_code_protect (.clock_i(clock_i), .rst_n_i(rst_n_i), .blank_i(blank_i),
        .load_config_i(cmd[5]), .load_data_i(cmd[4]), .load_word_i(word), .read_i(cmd[3]),
        .incr_i(cmd[2]), .begin_prog_i(cmd[1]), .end_prog_i(cmd[0]), .read_word_o(rd_w),
        .read_valid_o(rv), .pc_o(pc), .prog_active_o(pa), .prog_refused_o(refused),
        .parity_check_enable_o(dec[7]), .brownout_enable_o(dec[6]), .protect_select_high_o(dec[5]),
        .protect_select_low_o(dec[4]), .powerup_timer_enable_n_o(dec[3]),
        .watchdog_enable_o(dec[2]), .osc_select_high_o(dec[1]), .osc_select_low_o(dec[0]));
    cwp_prog u_cwp_prog (.clock_i(clock_i), .read_word_i(rd_w), .prog_refused_i(refused),
        .cmd_o(cmd), .word_o(word));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task rst(input logic blank);
        @(posedge clock_i);
        #1;
        rst_n_i = 1'b0;
        blank_i = blank;
        repeat (16) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        blank_i = 1'b0;
    endtask
    function automatic logic [15:0] exp_ck(input int md, input logic [15:0] c);
        logic [15:0] s, v;
        s = (c & 16'h3FFF) + ((md != 3) ? 16'h9876 : 16'h0000);
        for (int a = 0; a < 2048; a++) begin
            v = 16'hFFFF;
            for (int k = 0; k < 5; k++) if (ra[k] == a) v = rdt[k];
            if (md == 0 || (md == 1 && a >= 512) || (md == 2 && a >= 1024)) v = 16'h0000;
            s = s + v;
        end
        return s;
    endfunction
    // Ceiling well above four read-out sums plus programming
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        blank_i = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        for (m = 3; m >= 0; m--) begin
            rst(1'b1);
            check({rd_w[15:8], dec}, 16'h00FF);
            check({2'h0, pc}, 16'h0000);
            cfg = {{3{m[1:0]}}, m[1:0], m[1:0], ~m[1:0], m[1:0], m[1:0]};
            pos = 0;
            for (i = 0; i < 5; i++) begin
                u_cwp_prog.step(ra[i] - pos);
                pos = ra[i];
                u_cwp_prog.prog(rdt[i], r);
                check({15'h0, r}, 16'h0000);
            end
            u_cwp_prog.cmd(6'h20, 16'hFFFF);
            check({2'h0, pc}, 16'h2000);
            for (i = 0; i < 4; i++) begin
                u_cwp_prog.prog(16'hFFF9 - i, r);
                u_cwp_prog.step(1);
            end
            u_cwp_prog.step(3);
            u_cwp_prog.prog(cfg, r);
            check({15'h0, r}, 16'h0000);
            u_cwp_prog.verify(d, d2);
            check(d, cfg);
            check(d2, cfg);
            check({15'h0, rv}, 16'h0001);
            check({8'h0, dec}, {8'h0, cfg[9:2]});
            rst(1'b0);
            u_cwp_prog.checksum(m != 3, sum);
            check(sum, exp_ck(m, cfg));
            rst(1'b0);
            pos = 0;
            for (i = 0; i < 5; i++) begin
                u_cwp_prog.step(ra[i] - pos);
                pos = ra[i];
                u_cwp_prog.rd(d);
                check(d, rp[i][m] ? 16'h0000 : rdt[i]);
                u_cwp_prog.prog(16'h0000, r);
                check({15'h0, r}, {15'h0, rp[i][m]});
                u_cwp_prog.rd(d);
                check(d, 16'h0000);
            end
            // Try to erase the config word back to blank; cells only clear
            u_cwp_prog.cmd(6'h20, 16'hFFFF);
            u_cwp_prog.step(7);
            u_cwp_prog.cmd(6'h10, 16'hFFFF);
            u_cwp_prog.cmd(6'h02, 16'h0000);
            check({15'h0, pa}, 16'h0001);
            u_cwp_prog.cmd(6'h01, 16'h0000);
            check({14'h0, pa, refused}, 16'h0000);
            u_cwp_prog.rd(d);
            check(d, cfg);
        end
        results();
    end
endmodule // cwp_code_protect_test
`default_nettype wire
